// file: cond_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cond_if;
    logic level;
    logic act;
    modport src (output level, output act);
    modport dst (input level, input act);
endinterface : cond_if
`default_nettype wire

// file: counter_consts.svh
`ifndef COUNTER_CONSTS_SVH
`define COUNTER_CONSTS_SVH

// clock and derived timing
`define CLK_HZ        10000000
`define TICK_MS       10
`define TICK_CYC      (`CLK_HZ / 1000 * `TICK_MS)
`define GATE_MS       500
`define GATE_CYC      (`CLK_HZ / 1000 * `GATE_MS)
`define FREQ_MUL      (1000 / `GATE_MS)
`define RPM_MUL       (60000 / `GATE_MS)
`define HOUR_UNIT_S   36
`define HOUR_CYC      (`CLK_HZ * `HOUR_UNIT_S)
`define FILT_HZ       15
`define FILT_CYC      ((`CLK_HZ + `FILT_HZ - 1) / `FILT_HZ)
`define DEB_US        2000
`define DEB_CYC       (`CLK_HZ / 1000000 * `DEB_US)

// register byte offsets
`define REG_CTRL      8'h00
`define REG_OFFSET    8'h04
`define REG_SCALE     8'h08
`define REG_RESULT    8'h0C
`define REG_STATUS    8'h10

// control fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 3
`define CTRL_RNG_LSB  4
`define CTRL_RNG_MSB  5
`define CTRL_GATE     6
`define CTRL_FILT     7
`define CTRL_PROG     8
`define CTRL_MASK     32'h0000_01FF
`define CTRL_RST      32'h0000_0000
`define OFFSET_RST    32'h0000_0000
`define SCALE_MASK    32'h0000_3FFF
`define SCALE_RST     32'h0000_03E8

// status fields
`define ST_OVF        0
`define ST_UNF        1
`define ST_TEST       2
`define ST_RUN        3
`define ST_DONE       4

// resolution codes
`define RANGE_AUTO    2'h0
`define RANGE_X1      2'h1
`define RANGE_X10     2'h2

// digital input positions
`define DIN1          0
`define DIN2          1
`define DIN3          2
`define DIN4          3
`define DIN_EN        4
`define DIN_CNT       5
`define DIN_LOW_CNT   4

// arithmetic constants
`define DISP_MAX      48'sh0000_0001_869F
`define DISP_MIN      -48'sh0000_0000_270F
`define UNIT_ONE      48'sh0000_0000_03E8
`define DIV_TEN       48'sh0000_0000_000A
`define SPD_MS_NUM    48'sh0000_0000_000A
`define SPD_MS_DEN    48'sh0000_0000_0001
`define SPD_KMH_NUM   48'sh0000_0000_0024
`define SPD_KMH_DEN   48'sh0000_0000_000A

`endif

// file: counter_pkg.sv
`default_nettype none
package counter_pkg;
    typedef enum logic [3:0] {
        MODE_STOPWATCH = 4'b0000,
        MODE_COUNT_UP  = 4'b0001,
        MODE_COUNT_DN  = 4'b0010,
        MODE_PERIOD    = 4'b0011,
        MODE_DURATION  = 4'b0100,
        MODE_FREQ      = 4'b0101,
        MODE_RPM       = 4'b0110,
        MODE_HOURS     = 4'b0111,
        MODE_SPEED_MS  = 4'b1000,
        MODE_SPEED_KMH = 4'b1001
    } mode_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DONE = 2'b10
    } meas_state_type;
endpackage : counter_pkg
`default_nettype wire

// file: input_conditioner.sv
`timescale 1ns/1ps
`default_nettype none
`include "counter_consts.svh"
module input_conditioner #(
    parameter int unsigned DEB_CYC = `DEB_CYC,
    parameter bit          ACT_LOW = 1'b1
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    cond_if.src       sig
);
    logic        s1;
    logic        s2;
    logic [31:0] cnt;
    logic        act_raw;
    logic        settle;

    assign act_raw = s2 ^ ACT_LOW;
    assign settle  = (act_raw != sig.level) && (cnt == 32'(DEB_CYC - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1 <= ACT_LOW;
            s2 <= ACT_LOW;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
        end
    end

    // level must hold steady for the whole window before it is taken
    always_ff @(posedge clk_i) begin
        if (rst_i || act_raw == sig.level || settle) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 32'd1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sig.level <= 1'b0;
            sig.act   <= 1'b0;
        end else begin
            sig.act <= settle & act_raw;
            if (settle) begin
                sig.level <= act_raw;
            end
        end
    end
endmodule : input_conditioner
`default_nettype wire

// file: mmct_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mmct_checker
    import counter_pkg::*;
(
    input wire logic                        clk_i,
    input wire logic                        rst_i,
    input wire logic                        wb_cyc_i,
    input wire logic                        wb_stb_i,
    input wire logic                        wb_ack_o,
    input wire logic [3:0]                  din_n_i,
    input wire logic signed [31:0]          disp_value_o,
    input wire logic                        overflow_o,
    input wire logic                        underflow_o,
    input wire logic                        seg_test_o,
    input wire logic [1:0]                  alarm_lamp_o,
    input wire counter_pkg::meas_state_type meas_state_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_in1_on;
        !din_n_i[0] [*8];
    endsequence
    sequence s_in1_off;
        din_n_i[0] [*8];
    endsequence
    property p_ack_req;
        s_req |=> wb_ack_o;
    endproperty
    property p_ack_one;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_lamp;
        alarm_lamp_o == {2{seg_test_o}};
    endproperty
    property p_test_on;
        s_in1_on |-> ##[0:3] seg_test_o;
    endproperty
    property p_test_off;
        s_in1_off |-> ##[0:3] !seg_test_o;
    endproperty
    property p_test_deb;
        $rose(seg_test_o) |-> !din_n_i[0] && $past(din_n_i[0], 4) == 1'b0;
    endproperty
    property p_done_hold;
        meas_state_o == ST_DONE |=> meas_state_o inside {ST_DONE, ST_IDLE};
    endproperty
    property p_ovf;
        $stable(disp_value_o) && disp_value_o > 32'sd99999 |-> overflow_o;
    endproperty
    property p_unf;
        $stable(disp_value_o) && disp_value_o < -32'sd9999 |-> underflow_o;
    endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack missing after request");
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
    a_lamp: assert property (p_lamp) else $error("lamps differ from display test");
    a_test_on: assert property (p_test_on) else $error("display test not on");
    a_test_off: assert property (p_test_off) else $error("display test not off");
    a_test_deb: assert property (p_test_deb) else $error("display test on a glitch");
    a_done_hold: assert property (p_done_hold) else $error("result not held");
    a_ovf: assert property (p_ovf) else $error("overflow flag missing");
    a_unf: assert property (p_unf) else $error("underflow flag missing");
endmodule : mmct_checker
`default_nettype wire

// file: multimode_counter_timer_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "counter_consts.svh"
// Notes on behaviour
// - mode 0 is a stopwatch
// - stopwatch: in3 starts, in2 stops, in4 clears
// - mode 1 counts pulse rises upward
// - mode 2 counts pulse rises downward
// - count display applies offset and scale
// - counting: in2 gates, in3 reverses, in4 clears
// - resolution: auto, weight 1, weight 10
// - mode 3 measures rise to rise
// - period captured once, in4 rearms
// - mode 4 measures rise to fall
// - one high time per arm, in4 rearms
// - mode 5 frequency, two results per second
// - auto range disables scale in freq/rpm
// - mode 6 pulses per minute
// - mode 7 hours, optionally enable gated
// - hours cleared by in4, programming exit
// - mode 8 distance over time, m/s
// - mode 9 same, in km/h
// - speed distance fixed or programmed
// - filter ignores count pulses above 15 Hz
// - overflow and underflow display flags
// - in1 lights all segments and lamps
module multimode_counter_timer_core #(
    parameter int unsigned TICK_CYC = `TICK_CYC,
    parameter int unsigned GATE_CYC = `GATE_CYC,
    parameter int unsigned HOUR_CYC = `HOUR_CYC,
    parameter int unsigned FILT_CYC = `FILT_CYC,
    parameter int unsigned DEB_CYC  = `DEB_CYC
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [7:0]                 wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic      [31:0]                wb_dat_o,
    output logic                            wb_ack_o,
    input  wire logic                       pulse_i,
    input  wire logic [3:0]                 din_n_i,
    input  wire logic                       enable_i,
    output logic signed [31:0]              disp_value_o,
    output logic                            overflow_o,
    output logic                            underflow_o,
    output logic                            seg_test_o,
    output logic      [1:0]                 alarm_lamp_o,
    output var counter_pkg::meas_state_type meas_state_o
);
    import counter_pkg::*;

    logic        [31:0]   ctrl;
    logic signed [31:0]   offset;
    logic        [31:0]   scale;
    logic        [31:0]   ctrl_new;
    logic                 bus_req;
    logic                 bus_wr;
    logic                 clr;
    mode_type             mode;
    logic        [1:0]    range;
    logic [`DIN_CNT-1:0]  raw_pins;
    logic [`DIN_CNT-1:0]  din_lvl;
    logic [`DIN_CNT-1:0]  din_act;
    logic                 p1;
    logic                 p2;
    logic                 p3;
    logic                 p_rise;
    logic                 p_fall;
    meas_state_type       st;
    logic        [31:0]   presc;
    logic        [31:0]   tcnt;
    logic                 tick;
    logic                 start_stop;
    logic                 start_ev;
    logic                 stop_ev;
    logic        [31:0]   since;
    logic                 cnt_edge;
    logic                 count_mode;
    logic signed [31:0]   count;
    logic        [31:0]   gcnt;
    logic        [31:0]   ecnt;
    logic        [31:0]   fval;
    logic                 gate_end;
    logic        [31:0]   hpresc;
    logic        [31:0]   hours;
    logic                 hour_run;
    logic signed [47:0]   next_value;
    logic signed [47:0]   next_shown;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    assign mode  = mode_type'(ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
    assign range = ctrl[`CTRL_RNG_MSB:`CTRL_RNG_LSB];

    // register bus: one wait state, write lands on the acknowledged edge
    assign bus_req  = wb_cyc_i & wb_stb_i;
    assign bus_wr   = bus_req & wb_we_i & wb_ack_o;
    assign ctrl_new = merge(ctrl, wb_dat_i, wb_sel_i) & `CTRL_MASK;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (bus_req & ~wb_ack_o) begin
            case (wb_adr_i)
                `REG_CTRL:   wb_dat_o <= ctrl;
                `REG_OFFSET: wb_dat_o <= offset;
                `REG_SCALE:  wb_dat_o <= scale;
                `REG_RESULT: wb_dat_o <= disp_value_o;
                `REG_STATUS: begin
                    wb_dat_o              <= '0;
                    wb_dat_o[`ST_OVF]     <= overflow_o;
                    wb_dat_o[`ST_UNF]     <= underflow_o;
                    wb_dat_o[`ST_TEST]    <= seg_test_o;
                    wb_dat_o[`ST_RUN]     <= (st == ST_RUN);
                    wb_dat_o[`ST_DONE]    <= (st == ST_DONE);
                end
                default:     wb_dat_o <= '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl   <= `CTRL_RST;
            offset <= `OFFSET_RST;
            scale  <= `SCALE_RST;
        end else if (bus_wr) begin
            case (wb_adr_i)
                `REG_CTRL:   ctrl   <= ctrl_new;
                `REG_OFFSET: offset <= merge(offset, wb_dat_i, wb_sel_i);
                `REG_SCALE:  scale  <= merge(scale, wb_dat_i, wb_sel_i) & `SCALE_MASK;
                default:     ;
            endcase
        end
    end

    // any control write, programming exit among them, restarts all measurement
    assign clr = (bus_wr && wb_adr_i == `REG_CTRL) || din_act[`DIN4];

    assign raw_pins = {enable_i, din_n_i};

    generate
        for (genvar i = 0; i < `DIN_CNT; i++) begin : g_in
            cond_if c ();
            input_conditioner #(
                .DEB_CYC (DEB_CYC),
                .ACT_LOW (i < `DIN_LOW_CNT ? 1'b1 : 1'b0)
            ) u_cond (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .pin_i (raw_pins[i]),
                .sig   (c.src)
            );
            assign din_lvl[i] = c.level;
            assign din_act[i] = c.act;
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            p1 <= 1'b0;
            p2 <= 1'b0;
            p3 <= 1'b0;
        end else begin
            p1 <= pulse_i;
            p2 <= p1;
            p3 <= p2;
        end
    end

    assign p_rise = p2 & ~p3;
    assign p_fall = ~p2 & p3;

    // shared time base for stopwatch, period, duration and speed
    assign start_stop = (mode == MODE_STOPWATCH) || (mode == MODE_SPEED_MS) ||
                        (mode == MODE_SPEED_KMH);
    assign start_ev   = start_stop ? din_act[`DIN3] :
                        ((mode == MODE_PERIOD) || (mode == MODE_DURATION)) & p_rise;
    assign stop_ev    = start_stop ? din_act[`DIN2] :
                        (mode == MODE_PERIOD)   ? p_rise :
                        (mode == MODE_DURATION) ? p_fall : 1'b0;
    assign tick       = (presc == 32'(TICK_CYC - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i || clr) begin
            st <= ST_IDLE;
        end else begin
            case (st)
                ST_IDLE: if (start_ev) begin
                    st <= ST_RUN;
                end
                ST_RUN:  if (stop_ev) begin
                    st <= ST_DONE;
                end
                ST_DONE: st <= ST_DONE;
                default: st <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || st != ST_RUN || tick) begin
            presc <= '0;
        end else begin
            presc <= presc + 32'd1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || clr || (st == ST_IDLE && start_ev)) begin
            tcnt <= '0;
        end else if (st == ST_RUN && tick) begin
            tcnt <= tcnt + 32'd1;
        end
    end

    // filter: a rise counts only after a quiet spell of one slow period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            since <= 32'(FILT_CYC);
        end else if (p_rise) begin
            since <= '0;
        end else if (since < 32'(FILT_CYC)) begin
            since <= since + 32'd1;
        end
    end

    assign cnt_edge   = p_rise & (~ctrl[`CTRL_FILT] || since >= 32'(FILT_CYC));
    assign count_mode = (mode == MODE_COUNT_UP) || (mode == MODE_COUNT_DN);

    always_ff @(posedge clk_i) begin
        if (rst_i || clr) begin
            count <= '0;
        end else if (count_mode && cnt_edge && !din_lvl[`DIN2]) begin
            if ((mode == MODE_COUNT_UP) ^ din_lvl[`DIN3]) begin
                count <= count + 32'sd1;
            end else begin
                count <= count - 32'sd1;
            end
        end
    end

    // half-second gate for frequency and rpm
    assign gate_end = (gcnt == 32'(GATE_CYC - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i || clr || gate_end) begin
            gcnt <= '0;
        end else begin
            gcnt <= gcnt + 32'd1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || clr) begin
            ecnt <= '0;
            fval <= '0;
        end else if (gate_end) begin
            ecnt <= '0;
            fval <= ecnt + {31'd0, p_rise};
        end else begin
            ecnt <= ecnt + {31'd0, p_rise};
        end
    end

    assign hour_run = (mode == MODE_HOURS) && !ctrl[`CTRL_PROG] &&
                      (!ctrl[`CTRL_GATE] || din_lvl[`DIN_EN]);

    always_ff @(posedge clk_i) begin
        if (rst_i || clr || !hour_run || hpresc == 32'(HOUR_CYC - 1)) begin
            hpresc <= '0;
        end else begin
            hpresc <= hpresc + 32'd1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || clr) begin
            hours <= '0;
        end else if (hour_run && hpresc == 32'(HOUR_CYC - 1)) begin
            hours <= hours + 32'd1;
        end
    end

    always_comb begin
        logic signed [47:0] sc;
        logic signed [47:0] num;
        logic signed [47:0] den;
        sc  = $signed(48'(scale[13:0]));
        num = '0;
        den = '0;
        case (mode)
            MODE_STOPWATCH, MODE_PERIOD, MODE_DURATION: begin
                next_value = $signed(48'(tcnt));
            end
            MODE_COUNT_UP, MODE_COUNT_DN: begin
                next_value = (48'(count) + 48'(offset)) * sc / `UNIT_ONE;
            end
            MODE_FREQ, MODE_RPM: begin
                num = $signed(48'(fval)) *
                      ((mode == MODE_FREQ) ? 48'(`FREQ_MUL) : 48'(`RPM_MUL));
                next_value = (range == `RANGE_AUTO) ? num : num * sc / `UNIT_ONE;
            end
            MODE_HOURS: begin
                next_value = $signed(48'(hours));
            end
            MODE_SPEED_MS, MODE_SPEED_KMH: begin
                num = (range == `RANGE_AUTO) ? `UNIT_ONE : sc;
                num = num * ((mode == MODE_SPEED_MS) ? `SPD_MS_NUM : `SPD_KMH_NUM);
                den = $signed(48'(tcnt)) *
                      ((mode == MODE_SPEED_MS) ? `SPD_MS_DEN : `SPD_KMH_DEN);
                next_value = (st == ST_DONE && den != 48'sd0) ? num / den : 48'sd0;
            end
            default: next_value = '0;
        endcase
    end

    always_comb begin
        if (start_stop && mode != MODE_STOPWATCH) begin
            next_shown = next_value;
        end else begin
            case (range)
                `RANGE_X1:  next_shown = next_value;
                `RANGE_X10: next_shown = next_value / `DIV_TEN;
                default:    next_shown = (next_value > `DISP_MAX) ?
                                         next_value / `DIV_TEN : next_value;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            disp_value_o <= '0;
            overflow_o   <= 1'b0;
            underflow_o  <= 1'b0;
            meas_state_o <= ST_IDLE;
        end else begin
            disp_value_o <= next_shown[31:0];
            overflow_o   <= next_shown > `DISP_MAX;
            underflow_o  <= next_shown < `DISP_MIN;
            meas_state_o <= st;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seg_test_o   <= 1'b0;
            alarm_lamp_o <= 2'b00;
        end else begin
            seg_test_o   <= din_lvl[`DIN1];
            alarm_lamp_o <= {2{din_lvl[`DIN1]}};
        end
    end
endmodule : multimode_counter_timer_core
`default_nettype wire

// file: multimode_counter_timer_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "counter_consts.svh"
module multimode_counter_timer_core_tb_top;
    import counter_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic               clk_i, rst_i, cyc, stb, we, ack, pulse, ena, ovf, unf, tst;
    logic        [7:0]  adr;
    logic        [31:0] dat, rdat;
    logic        [3:0]  din_n, sel;
    logic        [1:0]  lamp;
    logic signed [31:0] disp;
    meas_state_type     mst;
    logic        [31:0] exp_q[$], msk_q[$];
    int                 tol_q[$];
    int                 n_fail, comparisons, n, off;
    int                 c3[3], e3[3], t3[3];

    multimode_counter_timer_core #(.TICK_CYC(10), .GATE_CYC(200), .HOUR_CYC(50),
        .FILT_CYC(40), .DEB_CYC(4)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pulse_i(pulse), .din_n_i(din_n), .enable_i(ena), .disp_value_o(disp),
        .overflow_o(ovf), .underflow_o(unf), .seg_test_o(tst), .alarm_lamp_o(lamp),
        .meas_state_o(mst));
    pulse_switch_model i_src (.clk_i(clk_i), .pulse_o(pulse), .din_n_o(din_n),
        .enable_o(ena));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic summarize();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] e, input logic [31:0] m, input int t,
                         input logic [31:0] s);
        logic signed [31:0] d;
        d = $signed(s & m) - $signed(e);
        comparisons++;
        if ((^d === 1'bx) || d > t || d < -t) begin
            n_fail++;
            $display("Error wb_dat_o expected %0d seen %0d", $signed(e), $signed(s & m));
        end
    endtask : check

    always @(posedge clk_i) begin
        if (cyc && !we && ack === 1'b1 && exp_q.size() > 0) begin
            check(exp_q.pop_front(), msk_q.pop_front(), tol_q.pop_front(), rdat);
        end
    end

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        bus(a, 1'b1, d, s);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                      input int t);
        exp_q.push_back(e);
        msk_q.push_back(m);
        tol_q.push_back(t);
        bus(a, 1'b0, 32'h0000_0000, 4'hF);
    endtask : rd

    initial begin
        repeat (40000) @(posedge clk_i);
        n_fail++;
        summarize();
    end

    initial begin
        {cyc, stb, we, adr, dat, sel} = '0;
        n_fail = 0;
        comparisons = 0;
        rst_i = 1'b1;
        void'($urandom(77));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`REG_CTRL, `CTRL_RST, ALL, 0);
        rd(`REG_OFFSET, `OFFSET_RST, ALL, 0);
        rd(`REG_SCALE, `SCALE_RST, ALL, 0);
        rd(`REG_STATUS, 32'h0000_0000, ALL, 0);
        wr(8'h20, ALL);
        rd(8'h20, 32'h0000_0000, ALL, 0);
        n = $urandom_range(15, 1);
        wr(`REG_CTRL, ALL, 4'(n));
        rd(`REG_CTRL, {{8{n[3]}}, {8{n[2]}}, {8{n[1]}}, {8{n[0]}}} & `CTRL_MASK, ALL, 0);
        n = $urandom_range(8, 1);
        off = $urandom_range(99, 0);
        wr(`REG_OFFSET, off);
        wr(`REG_SCALE, 32'h0000_07D0);
        wr(`REG_CTRL, 32'h0000_0011);
        i_src.train(n, 5, 5);
        rd(`REG_RESULT, (n + off) * 2, ALL, 0);
        i_src.sw(1, 1'b1);
        i_src.train(3, 5, 5);
        i_src.sw(1, 1'b0);
        rd(`REG_RESULT, (n + off) * 2, ALL, 0);
        i_src.sw(2, 1'b1);
        i_src.train(2, 5, 5);
        i_src.sw(2, 1'b0);
        rd(`REG_RESULT, (n - 2 + off) * 2, ALL, 0);
        i_src.tap(3);
        rd(`REG_RESULT, off * 2, ALL, 0);
        wr(`REG_OFFSET, 32'h0000_0000);
        wr(`REG_SCALE, `SCALE_RST);
        wr(`REG_CTRL, 32'h0000_0012);
        i_src.train(3, 5, 5);
        rd(`REG_RESULT, -3, ALL, 0);
        wr(`REG_OFFSET, -9999);
        rd(`REG_RESULT, -10002, ALL, 0);
        rd(`REG_STATUS, 32'h0000_0002, 32'h0000_0003, 0);
        wr(`REG_OFFSET, 99999);
        c3 = '{32'h21, 32'h01, 32'h11};
        e3 = '{10000, 10000, 100000};
        for (int i = 0; i < 3; i++) begin
            wr(`REG_CTRL, c3[i]);
            i_src.train(1, 5, 5);
            rd(`REG_RESULT, e3[i], ALL, 0);
        end
        rd(`REG_STATUS, 32'h0000_0001, 32'h0000_0003, 0);
        wr(`REG_OFFSET, 32'h0000_0000);
        wr(`REG_CTRL, 32'h0000_0091);
        repeat (50) @(posedge clk_i);
        i_src.train(3, 5, 55);
        i_src.train(4, 5, 5);
        rd(`REG_RESULT, 4, ALL, 0);
        wr(`REG_SCALE, 32'h0000_07D0);
        c3 = '{32'h10, 32'h08, 32'h19};
        e3 = '{20, 500, 360};
        t3 = '{2, 30, 20};
        for (int i = 0; i < 3; i++) begin
            wr(`REG_CTRL, c3[i]);
            i_src.tap(2);
            repeat (175) @(posedge clk_i);
            i_src.tap(1);
            rd(`REG_RESULT, e3[i], ALL, t3[i]);
            rd(`REG_STATUS, 32'h0000_0010, 32'h0000_0018, 0);
            i_src.tap(3);
            rd(`REG_RESULT, 32'h0000_0000, ALL, 0);
        end
        wr(`REG_CTRL, 32'h0000_0013);
        i_src.train(2, 5, 45);
        rd(`REG_RESULT, 5, ALL, 1);
        i_src.train(2, 5, 95);
        rd(`REG_RESULT, 5, ALL, 1);
        i_src.tap(3);
        i_src.train(2, 5, 95);
        rd(`REG_RESULT, 10, ALL, 1);
        wr(`REG_CTRL, 32'h0000_0014);
        i_src.train(1, 70, 10);
        rd(`REG_RESULT, 7, ALL, 1);
        i_src.train(1, 150, 10);
        rd(`REG_RESULT, 7, ALL, 1);
        i_src.tap(3);
        i_src.train(1, 150, 10);
        rd(`REG_RESULT, 15, ALL, 1);
        c3 = '{32'h05, 32'h15, 32'h06};
        e3 = '{20, 40, 1200};
        t3 = '{2, 4, 120};
        for (int i = 0; i < 3; i++) begin
            wr(`REG_CTRL, c3[i]);
            fork
                i_src.train(40, 10, 10);
                begin
                    repeat (650) @(posedge clk_i);
                    rd(`REG_RESULT, e3[i], ALL, t3[i]);
                end
            join
            repeat (450) @(posedge clk_i);
            rd(`REG_RESULT, 32'h0000_0000, ALL, 0);
        end
        wr(`REG_CTRL, 32'h0000_0007);
        repeat (500) @(posedge clk_i);
        rd(`REG_RESULT, 10, ALL, 1);
        i_src.tap(3);
        rd(`REG_RESULT, 0, ALL, 1);
        wr(`REG_CTRL, 32'h0000_0047);
        repeat (300) @(posedge clk_i);
        rd(`REG_RESULT, 0, ALL, 0);
        i_src.en(1'b1);
        repeat (250) @(posedge clk_i);
        rd(`REG_RESULT, 5, ALL, 1);
        wr(`REG_CTRL, 32'h0000_0147);
        wr(`REG_CTRL, 32'h0000_0047);
        rd(`REG_RESULT, 0, ALL, 0);
        i_src.sw(0, 1'b1);
        rd(`REG_STATUS, 32'h0000_0004, 32'h0000_0004, 0);
        i_src.sw(0, 1'b0);
        rd(`REG_STATUS, 32'h0000_0000, 32'h0000_0004, 0);
        summarize();
    end
endmodule : multimode_counter_timer_core_tb_top

bind multimode_counter_timer_core mmct_checker i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .din_n_i(din_n_i), .disp_value_o(disp_value_o),
    .overflow_o(overflow_o), .underflow_o(underflow_o), .seg_test_o(seg_test_o),
    .alarm_lamp_o(alarm_lamp_o), .meas_state_o(meas_state_o));
`default_nettype wire

// file: pulse_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_switch_model (
    input  wire logic  clk_i,
    output logic       pulse_o,
    output logic [3:0] din_n_o,
    output logic       enable_o
);
    // open contacts return to the pull-up, the pulse line rests on its pull-down
    initial begin
        pulse_o  = 1'b0;
        din_n_o  = 4'hF;
        enable_o = 1'b0;
    end
    task automatic sw(input int k, input logic on);
        @(posedge clk_i);
        din_n_o[k] <= !on;
        repeat (12) @(posedge clk_i);
    endtask : sw
    // a tap of input k closes its switch and opens it again
    task automatic tap(input int k);
        sw(k, 1'b1);
        sw(k, 1'b0);
    endtask : tap
    task automatic en(input logic on);
        @(posedge clk_i);
        enable_o <= on;
        repeat (12) @(posedge clk_i);
    endtask : en
    task automatic train(input int n, input int hi, input int lo);
        repeat (n) begin
            @(posedge clk_i);
            pulse_o <= 1'b1;
            repeat (hi) @(posedge clk_i);
            pulse_o <= 1'b0;
            repeat (lo - 1) @(posedge clk_i);
        end
    endtask : train
endmodule : pulse_switch_model
`default_nettype wire
